// file: fspa_host.sv
`timescale 1ns/1ns
module fspa_host
#(
    parameter bit TOP_BOOT = 1'b1
)
(
    // clock and reset
    input  wire logic                 clk_i,
    input  wire logic                 reset_n_i,
    // request
    input  wire logic                 req_valid_i,
    input  fspa_pkg::fspa_req_t       req_i,
    output logic                      req_ready_o,
    // answer
    output logic                      rsp_valid_o,
    output logic [7:0]                rsp_data_o,
    output logic [3:0]                rsp_sector_o,
    output logic                      id_mode_o,
    // supply status and temporary unprotect
    input  wire logic                 supply_low_i,
    input  wire logic                 unprot_req_i,
    output logic                      reset_id_level_o,
    // flash pins
    input  wire logic [7:0]           dq_i,
    output fspa_pkg::fspa_pins_t      pins_o
);

    typedef enum logic [1:0] {FSPA_IDLE, FSPA_RUN, FSPA_ANSWER} fspa_st_t;

    // ------------------------------------------------------------
    // sector decode
    // ------------------------------------------------------------
    // mirrors the device layout so callers can see which sector a
    // program or erase will land in, and hence which protection bit
    function automatic logic [3:0] sector_of(input logic [18:0] a, input logic top);
        logic [5:0] u;
        u = a[18:fspa_pkg::SECT_LSB];
        if (top)
        begin
            if (u[5:3] != 3'b111)      sector_of = {1'b0, u[5:3]};
            else if (!u[2])            sector_of = 4'h7;
            else if (u[1:0] == 2'b00)  sector_of = 4'h8;
            else if (u[1:0] == 2'b01)  sector_of = 4'h9;
            else                       sector_of = 4'hA;
        end
        else
        begin
            if (u[5:3] != 3'b000)      sector_of = 4'(u[5:3]) + 4'h3;
            else if (u[2])             sector_of = 4'h3;
            else if (!u[1])            sector_of = 4'h0;
            else if (!u[0])            sector_of = 4'h1;
            else                       sector_of = 4'h2;
        end
    endfunction

    fspa_st_t             st;
    fspa_st_t             next_st;
    logic [2:0]           step;
    logic [2:0]           next_step;
    logic [2:0]           nsteps;
    logic [2:0]           next_nsteps;
    fspa_pkg::fspa_req_t  cur;
    fspa_pkg::fspa_req_t  next_cur;
    logic                 idm;
    logic                 next_idm;
    logic [7:0]           next_rsp_data;
    logic [3:0]           next_rsp_sector;
    logic                 cyc_start;
    logic                 cyc_write;
    logic [18:0]          cyc_addr;
    logic [7:0]           cyc_data;
    logic                 cyc_done;
    logic [7:0]           cyc_rdata;
    logic                 cyc_done_pending;
    logic                 next_pending;

    // ------------------------------------------------------------
    // per-step cycle contents
    // ------------------------------------------------------------
    // every program and erase goes out behind its own unlock pair;
    // erase repeats the pair before the final command
    always_comb
    begin
        cyc_write = 1'b1;
        cyc_addr  = fspa_pkg::UNLOCK1_ADDR;
        cyc_data  = fspa_pkg::UNLOCK1_DATA;
        case (cur.op)
            fspa_pkg::FSPA_OP_READ,
            fspa_pkg::FSPA_OP_HV_ID_READ:
            begin
                cyc_write = 1'b0;
                cyc_addr  = cur.addr;
            end
            fspa_pkg::FSPA_OP_ID_EXIT:
                cyc_data = fspa_pkg::CMD_RESET;
            default:
            begin
                if (step == 3'd1 || step == 3'd4)
                begin
                    cyc_addr = fspa_pkg::UNLOCK2_ADDR;
                    cyc_data = fspa_pkg::UNLOCK2_DATA;
                end
                else if (step == 3'd2)
                begin
                    case (cur.op)
                        fspa_pkg::FSPA_OP_ID_ENTER: cyc_data = fspa_pkg::CMD_AUTOSEL;
                        fspa_pkg::FSPA_OP_PROGRAM:  cyc_data = fspa_pkg::CMD_PROGRAM;
                        default:                    cyc_data = fspa_pkg::CMD_ERASE;
                    endcase
                end
                // erase reuses step 3 for its second unlock pair
                else if (step == 3'd3 && cur.op == fspa_pkg::FSPA_OP_PROGRAM)
                begin
                    cyc_addr = cur.addr;
                    cyc_data = cur.data;
                end
                else if (step == 3'd5)
                begin
                    // chip erase goes to the unlock address, not the caller's
                    if (cur.op == fspa_pkg::FSPA_OP_SECT_ERASE)
                    begin
                        cyc_addr = cur.addr;
                        cyc_data = fspa_pkg::CMD_SECT_ERA;
                    end
                    else
                        cyc_data = fspa_pkg::CMD_CHIP_ERA;
                end
            end
        endcase
    end

    // ------------------------------------------------------------
    // request sequencing
    // ------------------------------------------------------------
    always_comb
    begin
        next_st         = st;
        next_step       = step;
        next_nsteps     = nsteps;
        next_cur        = cur;
        next_idm        = idm;
        next_rsp_data   = rsp_data_o;
        next_rsp_sector = rsp_sector_o;
        cyc_start       = 1'b0;
        case (st)
            FSPA_IDLE:
            begin
                // writes are pointless below lockout, so hold back every request, reads included
                if (req_valid_i && !supply_low_i)
                begin
                    next_cur        = req_i;
                    next_step       = 3'd0;
                    next_rsp_sector = sector_of(req_i.addr, TOP_BOOT);
                    case (req_i.op)
                        fspa_pkg::FSPA_OP_READ,
                        fspa_pkg::FSPA_OP_HV_ID_READ,
                        fspa_pkg::FSPA_OP_ID_EXIT:      next_nsteps = 3'd1;
                        fspa_pkg::FSPA_OP_ID_ENTER:     next_nsteps = 3'd3;
                        fspa_pkg::FSPA_OP_PROGRAM:      next_nsteps = 3'd4;
                        default:                        next_nsteps = 3'd6;
                    endcase
                    next_st = FSPA_RUN;
                end
            end
            FSPA_RUN:
            begin
                cyc_start = (step != nsteps) && !cyc_done_pending;
                if (cyc_done)
                begin
                    next_step = step + 3'd1;
                    if (step + 3'd1 == nsteps)
                    begin
                        next_rsp_data = cyc_rdata;
                        if (cur.op == fspa_pkg::FSPA_OP_ID_ENTER)
                            next_idm = 1'b1;
                        else if (cur.op == fspa_pkg::FSPA_OP_ID_EXIT)
                            next_idm = 1'b0;
                        next_st = FSPA_ANSWER;
                    end
                end
            end
            FSPA_ANSWER:
                next_st = FSPA_IDLE;
            default:
                next_st = FSPA_IDLE;
        endcase
    end

    // one cycle in flight at a time
    always_comb
    begin
        next_pending = cyc_done_pending;
        if (cyc_start)
            next_pending = 1'b1;
        else if (cyc_done)
            next_pending = 1'b0;
    end

    always_ff @(posedge clk_i)
    begin
        if (!reset_n_i)
        begin
            st               <= FSPA_IDLE;
            step             <= 3'd0;
            nsteps           <= 3'd0;
            cur              <= '0;
            idm              <= 1'b0;
            rsp_data_o       <= 8'h00;
            rsp_sector_o     <= 4'h0;
            cyc_done_pending <= 1'b0;
            reset_id_level_o <= 1'b0;
        end
        else
        begin
            st               <= next_st;
            step             <= next_step;
            nsteps           <= next_nsteps;
            cur              <= next_cur;
            idm              <= next_idm;
            rsp_data_o       <= next_rsp_data;
            rsp_sector_o     <= next_rsp_sector;
            cyc_done_pending <= next_pending;
            // elevated level on the reset pin while asked
            reset_id_level_o <= unprot_req_i;
        end
    end

    // handshake outputs
    assign req_ready_o = (st == FSPA_IDLE) && !supply_low_i;
    assign rsp_valid_o = (st == FSPA_ANSWER);
    assign id_mode_o   = idm;

    // ------------------------------------------------------------
    // pin cycle engine
    // ------------------------------------------------------------
    fspa_cycle u_cycle
    (
        .clk_i     (clk_i),
        .reset_n_i (reset_n_i),
        .start_i   (cyc_start),
        .write_i   (cyc_write),
        .addr_i    (cyc_addr),
        .data_i    (cyc_data),
        .hv_i      (cur.op == fspa_pkg::FSPA_OP_HV_ID_READ),
        .done_o    (cyc_done),
        .rdata_o   (cyc_rdata),
        .dq_i      (dq_i),
        .pins_o    (pins_o)
    );

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    a_unlock_first: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        cyc_start && cyc_write && step == 3'd0
        && cur.op inside {fspa_pkg::FSPA_OP_PROGRAM, fspa_pkg::FSPA_OP_SECT_ERASE}
        |-> cyc_addr == fspa_pkg::UNLOCK1_ADDR && cyc_data == fspa_pkg::UNLOCK1_DATA)
        else $error("program or erase not led by unlock cycle");
    a_erase_relock: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        cyc_start && step == 3'd3
        && cur.op inside {fspa_pkg::FSPA_OP_SECT_ERASE, fspa_pkg::FSPA_OP_CHIP_ERASE}
        |-> cyc_addr == fspa_pkg::UNLOCK1_ADDR && cyc_data == fspa_pkg::UNLOCK1_DATA)
        else $error("erase command not led by second unlock pair");
    a_no_write_lockout: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        supply_low_i && st == FSPA_IDLE |=> st == FSPA_IDLE)
        else $error("request taken during supply lockout");
    a_id_exit_reset: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        $fell(idm) |-> $past(cur.op) == fspa_pkg::FSPA_OP_ID_EXIT)
        else $error("id mode left without reset command");
    a_hv_only_read: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        pins_o.id_level_en |-> !pins_o.dq_oe)
        else $error("elevated id level during a write");
    a_answer_one: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        rsp_valid_o |=> !rsp_valid_o)
        else $error("answer held over two cycles");

    c_program:  cover property (@(posedge clk_i) rsp_valid_o && cur.op == fspa_pkg::FSPA_OP_PROGRAM);
    c_id_enter: cover property (@(posedge clk_i) $rose(idm));
    c_hv_read:  cover property (@(posedge clk_i) rsp_valid_o && cur.op == fspa_pkg::FSPA_OP_HV_ID_READ);
    c_erase:    cover property (@(posedge clk_i) rsp_valid_o && cur.op == fspa_pkg::FSPA_OP_SECT_ERASE);

endmodule // fspa_host

// file: fspa_pkg.sv
package fspa_pkg;

    // ------------------------------------------------------------
    // bus geometry
    // ------------------------------------------------------------
    localparam int ADDR_W = 19;
    localparam int DATA_W = 8;

    // ------------------------------------------------------------
    // identification addressing
    // ------------------------------------------------------------
    localparam logic [18:0] ID_OFS_MFR  = 19'h0_0000;
    localparam logic [18:0] ID_OFS_DEV  = 19'h0_0001;
    localparam logic [18:0] ID_OFS_PROT = 19'h0_0002;
    localparam int          SECT_LSB    = 13;
    localparam logic [7:0]  PROT_SET    = 8'h01;
    localparam logic [7:0]  PROT_CLR    = 8'h00;

    // ------------------------------------------------------------
    // command cycles (address, data)
    // ------------------------------------------------------------
    localparam logic [18:0] UNLOCK1_ADDR = 19'h0_0555;
    localparam logic [7:0]  UNLOCK1_DATA = 8'hAA;
    localparam logic [18:0] UNLOCK2_ADDR = 19'h0_02AA;
    localparam logic [7:0]  UNLOCK2_DATA = 8'h55;
    localparam logic [7:0]  CMD_AUTOSEL  = 8'h90;
    localparam logic [7:0]  CMD_PROGRAM  = 8'hA0;
    localparam logic [7:0]  CMD_ERASE    = 8'h80;
    localparam logic [7:0]  CMD_SECT_ERA = 8'h30;
    localparam logic [7:0]  CMD_CHIP_ERA = 8'h10;
    localparam logic [7:0]  CMD_RESET    = 8'hF0;

    // ------------------------------------------------------------
    // bus timing, in cycles of clk_i (8 ns)
    // ------------------------------------------------------------
    localparam int CLK_NS      = 8;
    localparam int SETUP_NS    = 16;
    localparam int STROBE_NS   = 48;
    localparam int SETUP_CYC   = (SETUP_NS + CLK_NS - 1) / CLK_NS;
    localparam int STROBE_CYC  = (STROBE_NS + CLK_NS - 1) / CLK_NS;

    // ------------------------------------------------------------
    // host requests
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        FSPA_OP_READ,
        FSPA_OP_PROGRAM,
        FSPA_OP_SECT_ERASE,
        FSPA_OP_CHIP_ERASE,
        FSPA_OP_ID_ENTER,
        FSPA_OP_ID_EXIT,
        FSPA_OP_HV_ID_READ
    } fspa_op_t;

    typedef struct packed {
        fspa_op_t    op;
        logic [18:0] addr;
        logic [7:0]  data;
    } fspa_req_t;

    // pins driven toward the flash
    typedef struct packed {
        logic        chip_sel_n;
        logic        out_gate_n;
        logic        wr_strobe_n;
        logic [18:0] addr;
        logic [7:0]  dq_out;
        logic        dq_oe;
        logic        id_level_en;
    } fspa_pins_t;

endpackage

// file: fspa_cycle.sv
`timescale 1ns/1ns
// single bus cycle engine: one read or one write on the flash pins
module fspa_cycle
(
    // clock and reset
    input  wire logic                clk_i,
    input  wire logic                reset_n_i,
    // cycle request
    input  wire logic                start_i,
    input  wire logic                write_i,
    input  wire logic [18:0]         addr_i,
    input  wire logic [7:0]          data_i,
    input  wire logic                hv_i,
    output logic                     done_o,
    output logic [7:0]               rdata_o,
    // flash pins
    input  wire logic [7:0]          dq_i,
    output fspa_pkg::fspa_pins_t     pins_o
);

    typedef enum logic [1:0] {FSPA_C_IDLE, FSPA_C_SETUP, FSPA_C_STROBE, FSPA_C_HOLD} fspa_cst_t;

    fspa_cst_t            st;
    fspa_cst_t            next_st;
    logic [3:0]           cnt;
    logic [3:0]           next_cnt;
    fspa_pkg::fspa_pins_t next_pins;
    logic [7:0]           next_rdata;
    logic                 next_done;

    // ------------------------------------------------------------
    // cycle sequencing
    // ------------------------------------------------------------
    // address settles before strobes fall, so the later falling edge
    // (write strobe) latches a stable address and its rising edge,
    // ending before chip select rises, latches the data
    always_comb
    begin
        next_st    = st;
        next_cnt   = cnt;
        next_pins  = pins_o;
        next_rdata = rdata_o;
        next_done  = 1'b0;
        case (st)
            FSPA_C_IDLE:
            begin
                if (start_i)
                begin
                    next_pins.addr        = addr_i;
                    next_pins.dq_out      = data_i;
                    next_pins.dq_oe       = write_i;
                    next_pins.id_level_en = hv_i;
                    next_pins.chip_sel_n  = 1'b0;
                    next_cnt              = 4'(fspa_pkg::SETUP_CYC);
                    next_st               = FSPA_C_SETUP;
                end
            end
            FSPA_C_SETUP:
            begin
                if (cnt > 4'h1)
                    next_cnt = cnt - 4'h1;
                else
                begin
                    // out gate stays high throughout a write
                    if (next_pins.dq_oe)
                        next_pins.wr_strobe_n = 1'b0;
                    else
                        next_pins.out_gate_n = 1'b0;
                    next_cnt = 4'(fspa_pkg::STROBE_CYC);
                    next_st  = FSPA_C_STROBE;
                end
            end
            FSPA_C_STROBE:
            begin
                if (cnt > 4'h1)
                    next_cnt = cnt - 4'h1;
                else
                begin
                    if (!pins_o.dq_oe)
                        next_rdata = dq_i;
                    next_pins.wr_strobe_n = 1'b1;
                    next_pins.out_gate_n  = 1'b1;
                    next_st               = FSPA_C_HOLD;
                end
            end
            FSPA_C_HOLD:
            begin
                next_pins.chip_sel_n  = 1'b1;
                next_pins.dq_oe       = 1'b0;
                next_pins.id_level_en = 1'b0;
                next_done             = 1'b1;
                next_st               = FSPA_C_IDLE;
            end
            default:
                next_st = FSPA_C_IDLE;
        endcase
    end

    // registers only
    always_ff @(posedge clk_i)
    begin
        if (!reset_n_i)
        begin
            st      <= FSPA_C_IDLE;
            cnt     <= 4'h0;
            rdata_o <= 8'h00;
            done_o  <= 1'b0;
            pins_o  <= '{chip_sel_n: 1'b1, out_gate_n: 1'b1, wr_strobe_n: 1'b1,
                         addr: 19'h0_0000, dq_out: 8'h00, dq_oe: 1'b0,
                         id_level_en: 1'b0};
        end
        else
        begin
            st      <= next_st;
            cnt     <= next_cnt;
            rdata_o <= next_rdata;
            done_o  <= next_done;
            pins_o  <= next_pins;
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    a_write_gate_high: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        !pins_o.wr_strobe_n |-> pins_o.out_gate_n && !pins_o.chip_sel_n)
        else $error("write strobe low with out gate low or chip deselected");
    a_gate_not_driven: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        !pins_o.out_gate_n |-> !pins_o.dq_oe)
        else $error("host drives data while out gate is low");
    a_addr_stable_strobe: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        !pins_o.wr_strobe_n && $past(!pins_o.wr_strobe_n) |-> $stable(pins_o.addr))
        else $error("address moved during write strobe");
    a_strobe_ends_first: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        $rose(pins_o.wr_strobe_n) |-> !pins_o.chip_sel_n && pins_o.dq_oe)
        else $error("data not held when write strobe rises");

endmodule // fspa_cycle

// file: fspa_flash_model.sv
`timescale 1ns/1ns
// pin-level flash, top boot layout; ids are arbitrary values
module fspa_flash_model
#(
    parameter logic [10:0] PROT_MASK = 11'h008,
    parameter logic [7:0]  MFR_ID    = 8'h3C,
    parameter logic [7:0]  DEV_ID    = 8'h5A
)
(
    // host side pins
    input  wire logic                 clk_i,
    input  wire fspa_pkg::fspa_pins_t pins_i,
    input  wire logic                 hv_reset_i,
    input  wire logic                 supply_low_i,
    // data toward the host
    output logic [7:0]                dq_o
);
    logic [7:0]  mem [logic [18:0]];
    logic [7:0]  last = 8'h00;
    logic [18:0] la = '0;
    logic        idm = 1'b0;
    logic        wd = 1'b0;
    logic        wa;
    int          step = 0;
    // write only with select and strobe low, gate high
    assign wa = !pins_i.chip_sel_n && !pins_i.wr_strobe_n && pins_i.out_gate_n;
    // sector index from the upper bits
    function automatic logic [3:0] sect(input logic [18:0] a);
        if (a[18:16] != 3'h7) return {1'b0, a[18:16]};
        if (!a[15]) return 4'h7;
        if (!a[14]) return 4'h8 + 4'(a[13]);
        return 4'hA;
    endfunction
    // lock lifts only while the reset pin is elevated
    function automatic logic open_s(input logic [18:0] a);
        return !PROT_MASK[sect(a)] || hv_reset_i;
    endfunction
    // id bytes come from a source apart from the array
    function automatic logic [7:0] rd(input logic [18:0] a);
        if (pins_i.id_level_en || idm)
            case (a[1:0])
                2'b00:   return MFR_ID;
                2'b01:   return DEV_ID;
                default: return {7'h00, PROT_MASK[sect(a)]};
            endcase
        return mem.exists(a) ? mem[a] : 8'hFF;
    endfunction
    // no pull on dq: a released line shows a changing pattern
    always_comb
        if (!pins_i.chip_sel_n && !pins_i.out_gate_n) dq_o = rd(pins_i.addr);
        else if (pins_i.dq_oe) dq_o = pins_i.dq_out;
        else dq_o = ~last;
    // command decoder; a wrong unlock cycle or setup command drops back to array read; id mode ends only on F0
    always @(posedge clk_i)
    begin
        last <= dq_o;
        wd <= wa;
        if (supply_low_i) step <= 0;
        else if (wa && !wd) la <= pins_i.addr;
        else if (!wa && wd)
        begin
            step <= 0;
            if (pins_i.dq_out == fspa_pkg::CMD_RESET) idm <= 1'b0;
            else if (!idm)
                case (step)
                    0, 3: if (la == fspa_pkg::UNLOCK1_ADDR && pins_i.dq_out == 8'hAA)
                        step <= step + 1;
                    1, 4: if (la == fspa_pkg::UNLOCK2_ADDR && pins_i.dq_out == 8'h55)
                        step <= step + 1;
                    2: if (la == fspa_pkg::UNLOCK1_ADDR)
                        case (pins_i.dq_out)
                            fspa_pkg::CMD_AUTOSEL: idm <= 1'b1;
                            fspa_pkg::CMD_PROGRAM: step <= 6;
                            fspa_pkg::CMD_ERASE:   step <= 3;
                            default:               step <= 0;
                        endcase
                    5: foreach (mem[k])
                        if (open_s(k) && (pins_i.dq_out == 8'h10 || sect(k) == sect(la)))
                            mem[k] = 8'hFF;
                    6: if (open_s(la)) mem[la] = pins_i.dq_out;
                    default: step <= 0;
                endcase
        end
    end
endmodule // fspa_flash_model

// file: testbench.sv
`timescale 1ns/1ns
module testbench;
    // ------------------------------------------------------------
    // signals, clock and instances
    // ------------------------------------------------------------
    localparam logic [7:0] MFR = 8'h3C; // arbitrary value
    localparam logic [7:0] DEV = 8'h5A; // arbitrary value
    logic                 clk_i = 1'b0;
    logic                 reset_n_i = 1'b0;
    logic                 req_valid_i = 1'b0;
    fspa_pkg::fspa_req_t  req_i = '0;
    logic                 supply_low_i = 1'b0;
    logic                 unprot_req_i = 1'b0;
    logic                 req_ready_o, rsp_valid_o, id_mode_o, hv_o;
    logic [7:0]           rsp_data_o, dq_i;
    logic [3:0]           rsp_sector_o;
    fspa_pkg::fspa_pins_t pins_o;
    int                   err_total = 0;
    int                   cmp_count = 0;
    // 125 MHz clock
    always #4 clk_i = ~clk_i;
    fspa_host #(.TOP_BOOT(1'b1)) DUT (.clk_i(clk_i), .reset_n_i(reset_n_i),
        .req_valid_i(req_valid_i), .req_i(req_i), .req_ready_o(req_ready_o),
        .rsp_valid_o(rsp_valid_o), .rsp_data_o(rsp_data_o), .rsp_sector_o(rsp_sector_o),
        .id_mode_o(id_mode_o), .supply_low_i(supply_low_i), .unprot_req_i(unprot_req_i),
        .reset_id_level_o(hv_o), .dq_i(dq_i), .pins_o(pins_o));
    fspa_flash_model #(.MFR_ID(MFR), .DEV_ID(DEV)) FLASH (.clk_i(clk_i), .pins_i(pins_o),
        .hv_reset_i(hv_o), .supply_low_i(supply_low_i), .dq_o(dq_i));
    task automatic give_verdict;
        $display("compares %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic check8(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            err_total++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // ------------------------------------------------------------
    // one request, held until taken, then wait for its answer
    // ------------------------------------------------------------
    task automatic do_req(input fspa_pkg::fspa_op_t op, input logic [18:0] a,
                          input logic [7:0] d);
        int n;
        @(posedge clk_i);
        req_i <= {op, a, d};
        req_valid_i <= 1'b1;
        for (n = 0; n < 300 && req_ready_o !== 1'b1; n++) @(negedge clk_i);
        @(posedge clk_i);
        req_valid_i <= 1'b0;
        for (n = n; n < 300 && rsp_valid_o !== 1'b1; n++) @(negedge clk_i);
        if (n >= 300)
        begin
            err_total++;
            give_verdict();
        end
    endtask
    task automatic rd_chk(input logic [18:0] a, input logic [7:0] e);
        do_req(fspa_pkg::FSPA_OP_READ, a, 8'h00);
        check8(rsp_data_o, e);
    endtask
    task automatic t_reset;
        @(negedge clk_i);
        check8({4'h0, pins_o.chip_sel_n, pins_o.wr_strobe_n, pins_o.dq_oe, req_ready_o}, 8'h0D);
        $display("t_reset done");
    endtask
    // boundary addresses of sectors 0 and 6 and of top boot sectors 7 to A
    task automatic t_sectors;
        logic [18:0] a [8] = '{19'h0_0000, 19'h6_FFFF, 19'h7_0000, 19'h7_7FFF,
                               19'h7_8000, 19'h7_A000, 19'h7_C000, 19'h7_FFFF};
        logic [3:0]  s [8] = '{4'h0, 4'h6, 4'h7, 4'h7, 4'h8, 4'h9, 4'hA, 4'hA};
        for (int i = 0; i < 8; i++)
        begin
            rd_chk(a[i], 8'hFF);
            check8({4'h0, rsp_sector_o}, {4'h0, s[i]});
        end
        $display("t_sectors done");
    endtask
    // sector 3 is locked in the model; elevated reset pin lifts it
    task automatic t_program;
        do_req(fspa_pkg::FSPA_OP_PROGRAM, 19'h1_2345, 8'hA5);
        rd_chk(19'h1_2345, 8'hA5);
        do_req(fspa_pkg::FSPA_OP_PROGRAM, 19'h3_0010, 8'h3C);
        rd_chk(19'h3_0010, 8'hFF);
        @(posedge clk_i);
        unprot_req_i <= 1'b1;
        repeat (2) @(negedge clk_i);
        check8({7'h00, hv_o}, 8'h01);
        do_req(fspa_pkg::FSPA_OP_PROGRAM, 19'h3_0010, 8'h3C);
        @(posedge clk_i);
        unprot_req_i <= 1'b0;
        rd_chk(19'h3_0010, 8'h3C);
        do_req(fspa_pkg::FSPA_OP_PROGRAM, 19'h3_0010, 8'h00);
        rd_chk(19'h3_0010, 8'h3C);
        $display("t_program done");
    endtask
    task automatic t_id;
        do_req(fspa_pkg::FSPA_OP_ID_ENTER, 19'h0_0000, 8'h00);
        check8({7'h00, id_mode_o}, 8'h01);
        rd_chk(19'h5_0000, MFR);
        rd_chk(19'h0_0001, DEV);
        rd_chk(19'h3_0002, 8'h01);
        rd_chk(19'h1_0002, 8'h00);
        do_req(fspa_pkg::FSPA_OP_ID_EXIT, 19'h0_0000, 8'h00);
        check8({7'h00, id_mode_o}, 8'h00);
        rd_chk(19'h1_2345, 8'hA5);
        do_req(fspa_pkg::FSPA_OP_HV_ID_READ, 19'h0_0001, 8'h00);
        check8(rsp_data_o, DEV);
        do_req(fspa_pkg::FSPA_OP_HV_ID_READ, 19'h3_0002, 8'h00);
        check8(rsp_data_o, 8'h01);
        $display("t_id done");
    endtask
    task automatic t_erase;
        do_req(fspa_pkg::FSPA_OP_SECT_ERASE, 19'h1_0000, 8'h00);
        rd_chk(19'h1_2345, 8'hFF);
        do_req(fspa_pkg::FSPA_OP_PROGRAM, 19'h2_0000, 8'h11);
        do_req(fspa_pkg::FSPA_OP_CHIP_ERASE, 19'h0_0000, 8'h00);
        rd_chk(19'h2_0000, 8'hFF);
        rd_chk(19'h3_0010, 8'h3C);
        $display("t_erase done");
    endtask
    // a request held through lockout must never reach the pins
    task automatic t_lockout;
        @(posedge clk_i);
        supply_low_i <= 1'b1;
        req_i <= {fspa_pkg::FSPA_OP_PROGRAM, 19'h1_0000, 8'h00};
        req_valid_i <= 1'b1;
        repeat (4) @(negedge clk_i);
        check8({6'h00, req_ready_o, pins_o.chip_sel_n}, 8'h01);
        @(posedge clk_i);
        req_valid_i <= 1'b0;
        supply_low_i <= 1'b0;
        @(negedge clk_i);
        check8({7'h00, req_ready_o}, 8'h01);
        $display("t_lockout done");
    endtask
    // main sequence
    initial
    begin
        repeat (16) @(posedge clk_i);
        reset_n_i <= 1'b1;
        t_reset();
        t_sectors();
        t_program();
        t_id();
        t_erase();
        t_lockout();
        give_verdict();
    end
endmodule // testbench
